// ===== hdl/fsms_pkg.sv
// fsms_pkg: constants shared by the flash mode/security front end.
// assumes a single 125 MHz clock domain and a plain register port.
package fsms_pkg;

  // clock
  localparam int CLK_PERIOD_NS = 8;

  // register offsets (byte addresses, one word each)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_MODE = 8'h04;
  localparam logic [7:0] REG_SECURITY = 8'h08;
  localparam logic [7:0] REG_BAUD = 8'h0C;
  localparam logic [7:0] REG_CMD = 8'h10;
  localparam logic [7:0] REG_RESULT = 8'h14;

  // field positions
  localparam int CTRL_SELF_PROG_BIT = 0;
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_BLOCK_LSB = 8;
  localparam int CMD_SEC_LSB = 16;
  localparam int SEC_BATCH_BIT = 0;
  localparam int SEC_BLOCK_BIT = 1;
  localparam int SEC_WRITE_BIT = 2;
  localparam int SEC_BOOT_BIT = 3;

  // reset values
  localparam logic [3:0] SEC_RESET = 4'h0;
  localparam logic [15:0] BAUD_RESET = 16'h0000;

  // flash mode pin pulse counts
  localparam logic [3:0] PULSES_UART_CRYSTAL = 4'h0;
  localparam logic [3:0] PULSES_UART_EXT_CLK = 4'h3;
  localparam logic [3:0] PULSES_UART_FAST_OSC = 4'h5;
  localparam logic [3:0] PULSES_SYNC_FAST_OSC = 4'h8;

  // quiet time that closes the pulse train
  localparam int QUIET_TIME_NS = 100000;
  localparam int QUIET_CYCLES = QUIET_TIME_NS / CLK_PERIOD_NS;

  // reset command byte is all zero: start bit plus eight data bits low
  localparam int SYNC_LOW_BITS = 9;

  typedef enum logic [1:0] {
    FSMS_OP_BATCH_ERASE,
    FSMS_OP_BLOCK_ERASE,
    FSMS_OP_WRITE,
    FSMS_OP_SET_SECURITY
  } fsms_op_type;

  typedef enum logic [1:0] {
    FSMS_LINK_NONE,
    FSMS_LINK_ASYNC,
    FSMS_LINK_SYNC
  } fsms_link_type;

  typedef enum logic [1:0] {
    FSMS_CLK_CRYSTAL,
    FSMS_CLK_EXTERNAL,
    FSMS_CLK_FAST_OSC
  } fsms_clk_type;

endpackage : fsms_pkg

// ===== hdl/fsms_guard_if.sv
// fsms_guard_if: command check request and verdict between top and guard.
// assumes both ends sit on ref_clk; the guard is purely combinational.
`timescale 1ns/1ns
`default_nettype none
interface fsms_guard_if;
  import fsms_pkg::*;
  fsms_op_type op;
  logic [7:0] block;
  logic [3:0] sec;
  logic self_prog;
  logic allow;
  logic clear_bw;

  modport guard (input op, input block, input sec, input self_prog,
                 output allow, output clear_bw);
  modport user (output op, output block, output sec, output self_prog,
                input allow, input clear_bw);
endinterface : fsms_guard_if
`default_nettype wire

// ===== hdl/fsms_guard.sv
// fsms_guard: decides whether a flash command passes the security bits.
// assumes op, block and security bits are stable while being checked.
`timescale 1ns/1ns
`default_nettype none
module fsms_guard #(
  parameter int BOOT_BLOCKS = 4
) (
  fsms_guard_if.guard chk
);
  import fsms_pkg::*;

  logic in_boot;
  logic batch_p;
  logic block_p;
  logic write_p;
  logic boot_p;

  always_comb begin
    in_boot = (chk.block < 8'(BOOT_BLOCKS));
    batch_p = chk.sec[SEC_BATCH_BIT];
    block_p = chk.sec[SEC_BLOCK_BIT];
    write_p = chk.sec[SEC_WRITE_BIT];
    boot_p = chk.sec[SEC_BOOT_BIT];
    chk.allow = 1'b0;
    chk.clear_bw = 1'b0;
    case (chk.op)
      FSMS_OP_BATCH_ERASE: begin
        // no batch erase from self programming
        chk.allow = !chk.self_prog && !batch_p && !boot_p;
        chk.clear_bw = chk.allow;
      end
      FSMS_OP_BLOCK_ERASE: begin
        if (chk.self_prog) begin
          chk.allow = !(boot_p && in_boot);
        end else begin
          chk.allow = !batch_p && !block_p && !(boot_p && in_boot);
        end
      end
      FSMS_OP_WRITE: begin
        if (chk.self_prog) begin
          chk.allow = !(boot_p && in_boot);
        end else begin
          chk.allow = !write_p && !(boot_p && in_boot);
        end
      end
      FSMS_OP_SET_SECURITY: begin
        chk.allow = 1'b1;
      end
      default: begin
        chk.allow = 1'b0;
      end
    endcase
  end

endmodule : fsms_guard
`default_nettype wire

// ===== hdl/fsms_mode_select.sv
// fsms_mode_select: flash programming front end; picks link and clock
// from flash mode pin pulses and filters flash commands by security bits.
// assumes all inputs synchronous to ref_clk; flash array sits outside.
//
// Function
// - count mode pin pulses: 0,3,5 pick async link, 8 picks sync link
// - async link: bit time measured from programmer's reset command
// - batch-erase prohibition refuses batch and block erase, keeps write
// - block-erase prohibition refuses block erase, keeps batch erase
// - boot prohibition refuses boot cluster 0 erase/write and batch erase
// - batch-erase and boot prohibitions are cleared by reset only
// - external batch erase clears block-erase and write prohibitions
// - self programming allows block erase/write except boot cluster when locked
// - no prohibition clears during self programming
`timescale 1ns/1ns
`default_nettype none
module fsms_mode_select #(
  parameter int QUIET_CYCLES = fsms_pkg::QUIET_CYCLES,
  parameter int BOOT_BLOCKS = 4
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic prog_mode,
  input wire logic flash_mode_pin,
  input wire logic async_rx,
  input wire logic [7:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic bus_write,
  input wire logic bus_read,
  output logic [31:0] bus_rdata,
  output fsms_pkg::fsms_link_type link_sel,
  output fsms_pkg::fsms_clk_type clk_sel,
  output logic link_ready,
  output logic mode_error,
  output logic [15:0] bit_cycles,
  output logic [3:0] security,
  output logic flash_req,
  output fsms_pkg::fsms_op_type flash_op,
  output logic [7:0] flash_block
);
  import fsms_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE, ST_COUNT, ST_WAIT_SYNC, ST_MEASURE, ST_READY, ST_BAD
  } fsms_state_type;

  fsms_state_type state, next_state;
  logic pin_last, next_pin_last;
  logic [3:0] pulses, next_pulses;
  logic [31:0] timer, next_timer;
  fsms_link_type next_link_sel;
  fsms_clk_type next_clk_sel;
  logic next_link_ready;
  logic next_mode_error;
  logic [15:0] next_bit_cycles;
  logic [3:0] next_security;
  logic self_prog, next_self_prog;
  logic next_flash_req;
  fsms_op_type next_flash_op;
  logic [7:0] next_flash_block;
  logic [1:0] result, next_result;
  logic [31:0] next_bus_rdata;
  logic cmd_write;

  fsms_guard_if chk();

  fsms_guard #(.BOOT_BLOCKS(BOOT_BLOCKS)) u_guard (
    .chk(chk)
  );

  assign cmd_write = bus_write && (bus_addr == REG_CMD);
  assign chk.op = fsms_op_type'(bus_wdata[CMD_OP_LSB +: 2]);
  assign chk.block = bus_wdata[CMD_BLOCK_LSB +: 8];
  assign chk.sec = security;
  assign chk.self_prog = self_prog;

  //////////////////////////////////////////////////////////////////////////
  // mode selection
  always_comb begin
    next_state = state;
    next_pin_last = flash_mode_pin;
    next_pulses = pulses;
    next_timer = timer;
    next_link_sel = link_sel;
    next_clk_sel = clk_sel;
    next_link_ready = link_ready;
    next_mode_error = mode_error;
    next_bit_cycles = bit_cycles;
    case (state)
      ST_IDLE: begin
        next_pulses = 4'h0;
        next_timer = 32'h0;
        next_link_ready = 1'b0;
        next_mode_error = 1'b0;
        next_link_sel = FSMS_LINK_NONE;
        // the programmer pulses only after entry, so start counting then
        if (prog_mode) begin
          next_state = ST_COUNT;
        end
      end
      ST_COUNT: begin
        if (flash_mode_pin && !pin_last) begin
          // saturate so a runaway train reads as a bad count
          if (pulses != 4'hF) begin
            next_pulses = pulses + 4'h1;
          end
          next_timer = 32'h0;
        end else if (timer >= 32'(QUIET_CYCLES - 1)) begin
          case (pulses)
            PULSES_UART_CRYSTAL: begin
              next_link_sel = FSMS_LINK_ASYNC;
              next_clk_sel = FSMS_CLK_CRYSTAL;
              next_state = ST_WAIT_SYNC;
            end
            PULSES_UART_EXT_CLK: begin
              next_link_sel = FSMS_LINK_ASYNC;
              next_clk_sel = FSMS_CLK_EXTERNAL;
              next_state = ST_WAIT_SYNC;
            end
            PULSES_UART_FAST_OSC: begin
              next_link_sel = FSMS_LINK_ASYNC;
              next_clk_sel = FSMS_CLK_FAST_OSC;
              next_state = ST_WAIT_SYNC;
            end
            PULSES_SYNC_FAST_OSC: begin
              next_link_sel = FSMS_LINK_SYNC;
              next_clk_sel = FSMS_CLK_FAST_OSC;
              next_link_ready = 1'b1;
              next_state = ST_READY;
            end
            default: begin
              next_mode_error = 1'b1;
              next_state = ST_BAD;
            end
          endcase
        end else begin
          next_timer = timer + 32'h1;
        end
      end
      ST_WAIT_SYNC: begin
        next_timer = 32'h0;
        if (!async_rx) begin
          next_timer = 32'h1;
          next_state = ST_MEASURE;
        end
      end
      ST_MEASURE: begin
        // low run of the reset command gives nine bit times
        if (async_rx) begin
          next_bit_cycles = 16'(timer / SYNC_LOW_BITS);
          next_link_ready = 1'b1;
          next_state = ST_READY;
        end else if (timer != 32'hFFFF_FFFF) begin
          next_timer = timer + 32'h1;
        end
      end
      ST_READY: begin
        next_state = ST_READY;
      end
      ST_BAD: begin
        next_state = ST_BAD;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    if (!prog_mode) begin
      next_state = ST_IDLE;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state <= ST_IDLE;
      pin_last <= 1'b0;
      pulses <= 4'h0;
      timer <= 32'h0;
      link_sel <= FSMS_LINK_NONE;
      clk_sel <= FSMS_CLK_CRYSTAL;
      link_ready <= 1'b0;
      mode_error <= 1'b0;
      bit_cycles <= BAUD_RESET;
    end else begin
      state <= next_state;
      pin_last <= next_pin_last;
      pulses <= next_pulses;
      timer <= next_timer;
      link_sel <= next_link_sel;
      clk_sel <= next_clk_sel;
      link_ready <= next_link_ready;
      mode_error <= next_mode_error;
      bit_cycles <= next_bit_cycles;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // command filter and register port
  always_comb begin
    next_security = security;
    next_self_prog = self_prog;
    next_flash_req = 1'b0;
    next_flash_op = flash_op;
    next_flash_block = flash_block;
    next_result = result;
    next_bus_rdata = 32'h0;
    if (bus_write && (bus_addr == REG_CTRL)) begin
      next_self_prog = bus_wdata[CTRL_SELF_PROG_BIT];
    end
    // external commands only once a link is up
    if (cmd_write) begin
      if ((link_ready || self_prog) && chk.allow) begin
        next_result = 2'b01;
        if (chk.op == FSMS_OP_SET_SECURITY) begin
          // only ever sets bits; nothing else touches 0 and 3
          next_security = security | bus_wdata[CMD_SEC_LSB +: 4];
        end else begin
          next_flash_req = 1'b1;
          next_flash_op = chk.op;
          next_flash_block = chk.block;
        end
        // guard never clears in self programming
        if (chk.clear_bw) begin
          next_security[SEC_BLOCK_BIT] = 1'b0;
          next_security[SEC_WRITE_BIT] = 1'b0;
        end
      end else begin
        next_result = 2'b10;
      end
    end
    if (bus_read) begin
      case (bus_addr)
        REG_CTRL: next_bus_rdata = {31'h0, self_prog};
        REG_MODE: next_bus_rdata = {20'h0, pulses, 2'h0, mode_error, link_ready,
                                    clk_sel, link_sel};
        REG_SECURITY: next_bus_rdata = {28'h0, security};
        REG_BAUD: next_bus_rdata = {16'h0, bit_cycles};
        REG_RESULT: next_bus_rdata = {30'h0, result};
        default: next_bus_rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      security <= SEC_RESET;
      self_prog <= 1'b0;
      flash_req <= 1'b0;
      flash_op <= FSMS_OP_BATCH_ERASE;
      flash_block <= 8'h00;
      result <= 2'b00;
      bus_rdata <= 32'h0;
    end else begin
      security <= next_security;
      self_prog <= next_self_prog;
      flash_req <= next_flash_req;
      flash_op <= next_flash_op;
      flash_block <= next_flash_block;
      result <= next_result;
      bus_rdata <= next_bus_rdata;
    end
  end

endmodule : fsms_mode_select
`default_nettype wire

// ===== tb/fsms_mode_select_monitor.sv
// fsms_mode_select_monitor: port checker for the mode/security front end
// assumes it is bound to fsms_mode_select from the bench top
`timescale 1ns/1ns
`default_nettype none
module fsms_mode_select_monitor #(
  parameter int BOOT_BLOCKS = 4
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic async_rx,
  input wire logic [7:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic bus_write,
  input var fsms_pkg::fsms_link_type link_sel,
  input var fsms_pkg::fsms_clk_type clk_sel,
  input wire logic link_ready,
  input wire logic mode_error,
  input wire logic [15:0] bit_cycles,
  input wire logic [3:0] security,
  input wire logic flash_req,
  input var fsms_pkg::fsms_op_type flash_op,
  input wire logic [7:0] flash_block
);
  import fsms_pkg::*;
  //////////////////////////////////////////
  // shadow of the self programming bit and the last low run on async_rx
  logic self_m;
  logic [15:0] run;
  logic [15:0] last_run;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      self_m <= 1'b0;
      run <= 16'h0000;
      last_run <= 16'h0000;
    end else begin
      if (bus_write && bus_addr == REG_CTRL) self_m <= bus_wdata[0];
      run <= async_rx ? 16'h0000 : run + 16'h0001;
      if (async_rx && run != 16'h0000) last_run <= run;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  sequence s_req(fsms_op_type o);
    flash_req && flash_op == o;
  endsequence
  sequence s_ext_req(fsms_op_type o);
    s_req(o) ##0 !$past(self_m);
  endsequence
  sequence s_async_done;
    $rose(link_ready) ##0 link_sel == FSMS_LINK_ASYNC;
  endsequence
  property p_batch_refused;
    s_req(FSMS_OP_BATCH_ERASE) |-> !security[0] && !security[3];
  endproperty
  a_batch_refused: assert property (p_batch_refused)
    else $error("batch erase passed a lock");
  property p_block_refused;
    s_ext_req(FSMS_OP_BLOCK_ERASE) |-> $past(security[1:0]) == 2'h0;
  endproperty
  a_block_refused: assert property (p_block_refused)
    else $error("block erase passed a lock");
  property p_boot_refused;
    flash_req && flash_op inside {FSMS_OP_BLOCK_ERASE, FSMS_OP_WRITE}
      && flash_block < BOOT_BLOCKS |-> !$past(security[3]);
  endproperty
  a_boot_refused: assert property (p_boot_refused)
    else $error("boot cluster touched");
  property p_write_refused;
    s_ext_req(FSMS_OP_WRITE) |-> !$past(security[2]);
  endproperty
  a_write_refused: assert property (p_write_refused)
    else $error("write passed its lock");
  property p_sticky;
    (security & 4'h9) != 4'h0 |=> (security & $past(security) & 4'h9) == ($past(security) & 4'h9);
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("permanent lock cleared");
  property p_self_no_clear;
    self_m |=> (security & $past(security)) == $past(security);
  endproperty
  a_self_no_clear: assert property (p_self_no_clear)
    else $error("lock cleared in self mode");
  property p_batch_clears;
    s_req(FSMS_OP_BATCH_ERASE) |-> ##[0:1] security[2:1] == 2'h0;
  endproperty
  a_batch_clears: assert property (p_batch_clears)
    else $error("batch erase kept locks");
  property p_link_clk;
    link_ready |-> !mode_error && (link_sel == FSMS_LINK_ASYNC
      || (link_sel == FSMS_LINK_SYNC && clk_sel == FSMS_CLK_FAST_OSC));
  endproperty
  a_link_clk: assert property (p_link_clk)
    else $error("bad link or clock pick");
  property p_async_bits;
    s_async_done |-> bit_cycles == last_run / 16'h0009;
  endproperty
  a_async_bits: assert property (p_async_bits)
    else $error("bit time mismatch");
endmodule : fsms_mode_select_monitor
`default_nettype wire

// ===== tb/fsms_programmer_model.sv
// fsms_programmer_model: external programmer driving mode pin and rx line
// assumes the bench calls run_select; all lines change after a clock edge
`timescale 1ns/1ns
`default_nettype none
module fsms_programmer_model #(
  parameter int QUIET = 20
) (
  input wire logic ref_clk,
  output logic prog_mode,
  output logic flash_mode_pin,
  output logic async_rx
);
  initial begin
    prog_mode = 1'b0;
    flash_mode_pin = 1'b0;
    async_rx = 1'b1;
  end
  // w sets pulse width so both prompt and slow programmers are covered
  task automatic run_select(input int n, input int w, input int bitc);
    @(posedge ref_clk);
    prog_mode <= 1'b0;
    repeat (4) @(posedge ref_clk);
    prog_mode <= 1'b1;
    repeat (3) @(posedge ref_clk);
    repeat (n) begin
      flash_mode_pin <= 1'b1;
      repeat (w) @(posedge ref_clk);
      flash_mode_pin <= 1'b0;
      repeat (w) @(posedge ref_clk);
    end
    if (bitc > 0) begin
      repeat (QUIET + 5) @(posedge ref_clk);
      async_rx <= 1'b0;
      // a little extra low time keeps the division off its boundary
      repeat (9 * bitc + 4) @(posedge ref_clk);
      async_rx <= 1'b1;
    end
  endtask : run_select
endmodule : fsms_programmer_model
`default_nettype wire

// ===== tb/test_flash_security_mode_select.sv
// test_flash_security_mode_select: table driven bench for fsms_mode_select
// assumes the programmer model and the bound port monitor
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_flash_security_mode_select;
  import fsms_pkg::*;
  typedef struct packed {
    logic s; logic [1:0] op; logic [7:0] blk; logic [3:0] sec; logic [1:0] res;
  } fsms_row_type;
  logic ref_clk, reset, prog_mode, flash_mode_pin, async_rx, bus_write, bus_read;
  logic link_ready, mode_error, flash_req;
  logic [7:0] bus_addr, flash_block;
  logic [31:0] bus_wdata, bus_rdata, d;
  logic [15:0] bit_cycles;
  logic [3:0] security;
  fsms_link_type link_sel;
  fsms_clk_type clk_sel;
  fsms_op_type flash_op;
  int n_mismatch, compares, n0;
  int nreq = 0;
  // pulses, width, bit time, expected {error, ready, clk, link}
  localparam int MODES [5][4] = '{'{2, 1, 0, 6'h20}, '{0, 1, 3, 6'h11},
    '{3, 3, 4, 6'h15}, '{5, 1, 6, 6'h19}, '{8, 3, 0, 6'h1A}};
  // rows run in order: the lock state carries over from row to row
  localparam fsms_row_type CMDS [22] = '{
    '{1'h0, 2'h2, 8'h03, 4'h0, 2'h1}, '{1'h0, 2'h1, 8'h04, 4'h0, 2'h1},
    '{1'h0, 2'h3, 8'h05, 4'h4, 2'h1}, '{1'h0, 2'h2, 8'h05, 4'h0, 2'h2},
    '{1'h0, 2'h3, 8'h05, 4'h2, 2'h1}, '{1'h0, 2'h1, 8'h05, 4'h0, 2'h2},
    '{1'h0, 2'h0, 8'h00, 4'h0, 2'h1}, '{1'h0, 2'h2, 8'h05, 4'h0, 2'h1},
    '{1'h1, 2'h3, 8'h05, 4'h6, 2'h1}, '{1'h1, 2'h1, 8'h05, 4'h0, 2'h1},
    '{1'h1, 2'h2, 8'h05, 4'h0, 2'h1}, '{1'h1, 2'h0, 8'h00, 4'h0, 2'h2},
    '{1'h0, 2'h0, 8'h00, 4'h0, 2'h1}, '{1'h0, 2'h3, 8'h00, 4'h8, 2'h1},
    '{1'h0, 2'h2, 8'h03, 4'h0, 2'h2}, '{1'h0, 2'h2, 8'h04, 4'h0, 2'h1},
    '{1'h0, 2'h0, 8'h00, 4'h0, 2'h2}, '{1'h1, 2'h2, 8'h03, 4'h0, 2'h2},
    '{1'h0, 2'h3, 8'h00, 4'h1, 2'h1}, '{1'h1, 2'h1, 8'h05, 4'h0, 2'h1},
    '{1'h0, 2'h1, 8'h04, 4'h0, 2'h2}, '{1'h0, 2'h2, 8'h04, 4'h0, 2'h1}};
  fsms_mode_select #(.QUIET_CYCLES(20), .BOOT_BLOCKS(4)) uut (.ref_clk(ref_clk),
    .reset(reset), .prog_mode(prog_mode), .flash_mode_pin(flash_mode_pin),
    .async_rx(async_rx), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_write(bus_write), .bus_read(bus_read), .bus_rdata(bus_rdata),
    .link_sel(link_sel), .clk_sel(clk_sel), .link_ready(link_ready),
    .mode_error(mode_error), .bit_cycles(bit_cycles), .security(security),
    .flash_req(flash_req), .flash_op(flash_op), .flash_block(flash_block));
  fsms_programmer_model #(.QUIET(20)) prog (.ref_clk(ref_clk), .prog_mode(prog_mode),
    .flash_mode_pin(flash_mode_pin), .async_rx(async_rx));
  //////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) if (flash_req === 1'b1) nreq <= nreq + 1;
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    bus_addr <= a;
    bus_wdata <= v;
    bus_write <= 1'b1;
    @(posedge ref_clk);
    bus_write <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge ref_clk);
    bus_addr <= a;
    bus_read <= 1'b1;
    @(posedge ref_clk);
    bus_read <= 1'b0;
    @(posedge ref_clk);
    v = bus_rdata;
  endtask : rd
  task automatic close_out();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : close_out
  task automatic wait_link();
    int i;
    for (i = 0; i < 400; i++) begin
      @(posedge ref_clk);
      if (link_ready === 1'b1 || mode_error === 1'b1) break;
    end
    if (i == 400) begin
      n_mismatch++;
      close_out();
    end
  endtask : wait_link
  initial begin
    logic [5:0] e;
    reset = 1'b1;
    bus_addr = 8'h00;
    bus_wdata = 32'h0;
    bus_write = 1'b0;
    bus_read = 1'b0;
    n_mismatch = 0;
    compares = 0;
    repeat (16) @(posedge ref_clk);
    reset <= 1'b0;
    rd(REG_MODE, d);
    `CHK(d, 32'h0)
    rd(8'h20, d);
    `CHK(d, 32'h0)
    // no link yet and no self programming: commands must bounce
    wr(REG_CMD, 32'h2);
    rd(REG_RESULT, d);
    `CHK(d, 32'h2)
    wr(REG_SECURITY, 32'hF);
    rd(REG_SECURITY, d);
    `CHK(d, 32'h0)
    for (int i = 0; i < 5; i++) begin
      e = 6'(MODES[i][3]);
      prog.run_select(MODES[i][0], MODES[i][1], MODES[i][2]);
      wait_link();
      rd(REG_MODE, d);
      `CHK(d[5:4], e[5:4])
      if (e[5] == 1'b0) `CHK(d[3:0], e[3:0])
      `CHK(d[11:8], MODES[i][0][3:0])
      if (MODES[i][2] > 0) begin
        rd(REG_BAUD, d);
        `CHK(d[15:0], MODES[i][2][15:0])
      end
    end
    for (int i = 0; i < 22; i++) begin
      wr(REG_CTRL, {31'h0, CMDS[i].s});
      n0 = nreq;
      wr(REG_CMD, {12'h0, CMDS[i].sec, CMDS[i].blk, 6'h0, CMDS[i].op});
      rd(REG_RESULT, d);
      `CHK(d[1:0], CMDS[i].res)
      if (CMDS[i].op != 2'h3) `CHK(nreq - n0, int'(CMDS[i].res == 2'h1))
      if (CMDS[i].op != 2'h3 && CMDS[i].res == 2'h1)
        `CHK({flash_op, flash_block}, {CMDS[i].op, CMDS[i].blk})
    end
    `CHK(security, 4'h9)
    @(posedge ref_clk);
    reset <= 1'b1;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    `CHK(security, 4'h0)
    `CHK(link_sel, FSMS_LINK_NONE)
    close_out();
  end
endmodule : test_flash_security_mode_select
bind fsms_mode_select fsms_mode_select_monitor #(.BOOT_BLOCKS(BOOT_BLOCKS)) mon (
  .ref_clk(ref_clk), .reset(reset), .async_rx(async_rx), .bus_addr(bus_addr),
  .bus_wdata(bus_wdata), .bus_write(bus_write), .link_sel(link_sel),
  .clk_sel(clk_sel), .link_ready(link_ready), .mode_error(mode_error),
  .bit_cycles(bit_cycles), .security(security), .flash_req(flash_req),
  .flash_op(flash_op), .flash_block(flash_block));
`default_nettype wire
